// file: bc_sequencer_queue_msg_blocks.sv
// Sequencer engine for decrement-skip, flag, queue push and message block instructions.
// Notes on behaviour
// - True condition: decrement addressed RAM word; skip next instruction when result zero.
// - False condition: memory untouched, continue with the following op code.
// - Flag op code 0x0C runs unconditionally, modifying low byte of flag register 0x0037.
// - Parameter upper and lower bytes give one 2-bit argument per flag.
// - Queue is a 64-word circular buffer in RAM, filled by op codes.
// - Pushes carry block status, time tag, immediate values or RAM contents.
// - Queue pointer register 0x0038 resets to base address 0x00C0.
// - Host may write a new queue base; device then uses it.
// - Each push advances the pointer to the next write address.
// - Every 64th word the pointer wraps from end back to base.
// - Bit 13 of register 0x0010 enables an interrupt on each wrap.
// - Execute-message parameter is block start address; first word is control word.
// - Normal block holds eight words in fixed order.
// - RT-to-RT block extends to sixteen words with extra command and status.
// - RT-to-RT: command word is receive command; transmitter status in eighth word.
// - Data pointer used for subaddress and mode-with-data, ignored otherwise.
// - Next message waits until the time-to-next count expires.
// - Time tag word written at start and again at end of message.
// - 32-bit time base: tag word bits 15-0, word 7 bits 31-16.
// - 16-bit time base: word 7 holds last transmitted word.
// - Control word is never sent on the bus; host maintains it.
// - Nonzero time-to-next word loads message timer 0x0036, which counts down.
`timescale 1ns/10ps
`default_nettype none
`include "bcq_consts.svh"

module bc_sequencer_queue_msg_blocks
	import bcq_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        resetn,
	// Instruction port from the sequencer fetch logic.
	input  wire logic        instr_valid,
	input  wire logic [4:0]  instr_op,
	input  wire logic [15:0] instr_param,
	input  wire logic        cond_true,
	input  wire logic [15:0] push_value,
	output logic             instr_done,
	output logic             skip_next,
	// Shared RAM port.
	output logic             ram_req,
	output logic             ram_we,
	output logic [12:0]      ram_addr,
	output logic [15:0]      ram_wdata,
	input  wire logic [15:0] ram_rdata,
	input  wire logic        ram_ack,
	// Host register port.
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic [15:0]      reg_rdata,
	// Time base and message engine.
	input  wire logic [31:0] time_count,
	input  wire logic        time32_sel,
	input  wire logic        msg_end,
	input  wire logic        end_rt_rt,
	input  wire logic [15:0] end_bsw,
	input  wire logic [15:0] end_status,
	input  wire logic [15:0] end_rx_status,
	input  wire logic [15:0] end_last_tx,
	output logic             msg_go,
	output logic [15:0]      msg_ctrl,
	output logic [15:0]      msg_cmd,
	output logic [15:0]      msg_dptr,
	output logic             msg_dptr_used,
	// Flags and interrupt.
	output logic [7:0]       gp_flags,
	output logic             queue_wrap_irq
);

	state_s r;
	state_s n;

	function automatic logic [7:0] flag_apply(input logic [7:0] f, input logic [15:0] p);
		logic [7:0] res;
		res = f;
		for (int i = 0; i < 8; i++) begin
			case ({p[8+i], p[i]})
				2'b01:   res[i] = 1'b1;
				2'b10:   res[i] = 1'b0;
				2'b11:   res[i] = ~f[i];
				default: res[i] = f[i];
			endcase
		end
		return res;
	endfunction : flag_apply

	function automatic logic is_push(input logic [4:0] op);
		return (op == `OP_PUSH_IMM) || (op == `OP_PUSH_VAL) || (op == `OP_PUSH_MEM);
	endfunction : is_push

	function automatic logic [15:0] wb_off(input logic [3:0] idx);
		case (idx)
			4'h0:    wb_off = `MB_TTAG;
			4'h1:    wb_off = `MB_BSW;
			4'h2:    wb_off = `MB_W7;
			4'h3:    wb_off = `MB_STATUS;
			default: wb_off = `MB_RX_STATUS;
		endcase
	endfunction : wb_off

	function automatic logic [15:0] wb_val(input logic [3:0] idx, input logic [31:0] tt,
			input logic t32, input logic [15:0] lb);
		case (idx)
			4'h0:    wb_val = tt[15:0];
			4'h1:    wb_val = end_bsw;
			4'h2:    wb_val = t32 ? tt[31:16] : lb;
			4'h3:    wb_val = end_status;
			default: wb_val = end_rx_status;
		endcase
	endfunction : wb_val

	always_comb begin
		logic        push_en;
		logic [15:0] push_word;
		logic        pop_en;
		logic [15:0] addr;
		push_en   = 1'b0;
		push_word = 16'h0000;
		pop_en    = 1'b0;
		addr      = 16'h0000;
		n         = r;
		n.done    = 1'b0;
		n.irq     = 1'b0;
		n.go      = 1'b0;

		// Message timer counts down one step per microsecond.
		if (r.timer != 16'h0000) begin
			if (r.pre == `TTNM_PRE_LAST) begin
				n.pre   = 5'h00;
				n.timer = r.timer - 16'h0001;
			end else begin
				n.pre = r.pre + 5'h01;
			end
		end

		case (r.st)
			S_IDLE: begin
				// Nothing is taken while done shows, so an offer held up to that edge runs once.
				if (instr_valid && !r.done && !(is_push(instr_op) && r.fcnt == 2'd2)) begin
					n.param = instr_param;
					n.skip  = 1'b0;
					case (instr_op)
						`OP_DECREMENT_SKIP_IF_ZERO: begin
							if (cond_true) begin
								n.ram_req  = 1'b1;
								n.ram_we   = 1'b0;
								n.ram_addr = instr_param[12:0];
								n.st       = S_DEC_RD;
							end else begin
								n.done = 1'b1;
							end
						end
						`OP_FLAG_MODIFY_INSTR: begin
							n.flags = flag_apply(r.flags, instr_param);
							n.done  = 1'b1;
						end
						`OP_PUSH_IMM: begin
							push_en   = cond_true;
							push_word = instr_param;
							n.done    = 1'b1;
						end
						`OP_PUSH_VAL: begin
							push_en   = cond_true;
							push_word = push_value;
							n.done    = 1'b1;
						end
						`OP_PUSH_MEM: begin
							if (cond_true) begin
								n.ram_req  = 1'b1;
								n.ram_we   = 1'b0;
								n.ram_addr = instr_param[12:0];
								n.st       = S_PMEM;
							end else begin
								n.done = 1'b1;
							end
						end
						`OP_EXEC_MSG: begin
							n.cnt      = 4'h0;
							n.ram_req  = 1'b1;
							n.ram_we   = 1'b0;
							addr       = instr_param + `MB_CTRL;
							n.ram_addr = addr[12:0];
							n.st       = S_MSG_RD;
						end
						default: begin
							n.done = 1'b1;
						end
					endcase
				end else if (r.fcnt != 2'd0) begin
					pop_en      = 1'b1;
					n.ram_req   = 1'b1;
					n.ram_we    = 1'b1;
					n.ram_addr  = r.qptr[12:0];
					n.ram_wdata = r.fmem[r.frp];
					n.st        = S_QWR;
				end
			end
			S_DEC_RD: begin
				if (ram_ack) begin
					n.data      = ram_rdata - 16'h0001;
					n.ram_we    = 1'b1;
					n.ram_wdata = ram_rdata - 16'h0001;
					n.st        = S_DEC_WR;
				end
			end
			S_DEC_WR: begin
				if (ram_ack) begin
					n.ram_req = 1'b0;
					n.done    = 1'b1;
					n.skip    = (r.data == 16'h0000);
					n.st      = S_IDLE;
				end
			end
			S_PMEM: begin
				if (ram_ack) begin
					n.ram_req = 1'b0;
					push_en   = 1'b1;
					push_word = ram_rdata;
					n.done    = 1'b1;
					n.st      = S_IDLE;
				end
			end
			S_QWR: begin
				if (ram_ack) begin
					n.ram_req = 1'b0;
					n.st      = S_IDLE;
					if (r.qcnt == `QUEUE_LAST) begin
						n.qptr = r.qbase;
						n.qcnt = 6'h00;
						n.irq  = r.qien;
					end else begin
						n.qptr = r.qptr + 16'h0001;
						n.qcnt = r.qcnt + 6'h01;
					end
				end
			end
			S_MSG_RD: begin
				if (ram_ack) begin
					case (r.cnt)
						4'h0:    n.ctrl = ram_rdata;
						4'h1:    n.cmd  = ram_rdata;
						4'h2:    n.dptr = ram_rdata;
						default: n.ttnm = ram_rdata;
					endcase
					if (r.cnt == `MB_TTNM) begin
						n.ram_req = 1'b0;
						n.st      = S_MSG_WAIT;
					end else begin
						addr       = r.param + 16'(r.cnt) + 16'h0001;
						n.cnt      = r.cnt + 4'h1;
						n.ram_addr = addr[12:0];
					end
				end
			end
			S_MSG_WAIT: begin
				if (r.timer == 16'h0000) begin
					n.go        = 1'b1;
					n.dptr_used = (r.cmd[9:5] != 5'h00 && r.cmd[9:5] != 5'h1f)
						|| r.cmd[4];
					if (r.ttnm != 16'h0000) begin
						n.timer = r.ttnm;
						n.pre   = 5'h00;
					end
					addr        = r.param + `MB_TTAG;
					n.ram_req   = 1'b1;
					n.ram_we    = 1'b1;
					n.ram_addr  = addr[12:0];
					n.ram_wdata = time_count[15:0];
					n.st        = S_MSG_TT;
				end
			end
			S_MSG_TT: begin
				if (ram_ack) begin
					n.ram_req = 1'b0;
					n.st      = S_MSG_RUN;
				end
			end
			S_MSG_RUN: begin
				if (msg_end) begin
					n.ttag      = time_count;
					n.cnt       = 4'h0;
					addr        = r.param + wb_off(4'h0);
					n.ram_req   = 1'b1;
					n.ram_we    = 1'b1;
					n.ram_addr  = addr[12:0];
					n.ram_wdata = time_count[15:0];
					n.st        = S_MSG_WB;
				end
			end
			S_MSG_WB: begin
				if (ram_ack) begin
					if (r.cnt == (end_rt_rt ? 4'h4 : 4'h3)) begin
						n.ram_req = 1'b0;
						n.done    = 1'b1;
						n.st      = S_IDLE;
					end else begin
						n.cnt       = r.cnt + 4'h1;
						addr        = r.param + wb_off(r.cnt + 4'h1);
						n.ram_addr  = addr[12:0];
						n.ram_wdata = wb_val(r.cnt + 4'h1, r.ttag, time32_sel,
							end_last_tx);
					end
				end
			end
			default: begin
				n.st      = S_IDLE;
				n.ram_req = 1'b0;
			end
		endcase

		// Two-entry buffer between push sources and the queue writer.
		if (push_en) begin
			n.fmem[r.fwp] = push_word;
			n.fwp         = ~r.fwp;
		end
		if (pop_en) begin
			n.frp = ~r.frp;
		end
		n.fcnt = r.fcnt + {1'b0, push_en} - {1'b0, pop_en};

		// Host register writes take effect last, so relocation overrides an advance.
		if (reg_wr) begin
			case (reg_addr)
				`REG_GP_QUEUE_PTR: begin
					n.qbase = reg_wdata;
					n.qptr  = reg_wdata;
					n.qcnt  = 6'h00;
				end
				`REG_IRQ_ENABLE:    n.qien  = reg_wdata[`QWRAP_IEN_BIT];
				`REG_GP_FLAG_WRITE: n.flags = reg_wdata[7:0];
				default:            n.qien  = n.qien;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`REG_GP_QUEUE_PTR: n.rdata = r.qptr;
				`REG_IRQ_ENABLE:   n.rdata = 16'(r.qien) << `QWRAP_IEN_BIT;
				default:           n.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			r       <= '0;
			r.st    <= S_IDLE;
			r.qptr  <= `QPTR_RST;
			r.qbase <= `QPTR_RST;
		end else begin
			r <= n;
		end
	end

	assign instr_done     = r.done;
	assign skip_next      = r.skip;
	assign ram_req        = r.ram_req;
	assign ram_we         = r.ram_we;
	assign ram_addr       = r.ram_addr;
	assign ram_wdata      = r.ram_wdata;
	assign reg_rdata      = r.rdata;
	assign msg_go         = r.go;
	assign msg_ctrl       = r.ctrl;
	assign msg_cmd        = r.cmd;
	assign msg_dptr       = r.dptr;
	assign msg_dptr_used  = r.dptr_used;
	assign gp_flags       = r.flags;
	assign queue_wrap_irq = r.irq;

	sequence s_dec_write_ack;
		r.st == S_DEC_WR && ram_ack;
	endsequence

	sequence s_qwr_ack;
		r.st == S_QWR && ram_ack && !reg_wr;
	endsequence

	property p_dec_skip;
		@(posedge mclk) disable iff (!resetn)
		s_dec_write_ack |=> instr_done && (skip_next == (r.data == 16'h0000));
	endproperty
	a_dec_skip: assert property (p_dec_skip) else $error("skip does not match result");

	property p_dec_false;
		@(posedge mclk) disable iff (!resetn)
		r.st == S_IDLE && instr_valid && !r.done
			&& instr_op == `OP_DECREMENT_SKIP_IF_ZERO && !cond_true
			|=> instr_done && !skip_next && !ram_req;
	endproperty
	a_dec_false: assert property (p_dec_false) else $error("false decrement touched memory");

	property p_flag;
		@(posedge mclk) disable iff (!resetn)
		r.st == S_IDLE && instr_valid && !r.done && instr_op == `OP_FLAG_MODIFY_INSTR && !reg_wr
			|=> gp_flags == flag_apply($past(r.flags), $past(instr_param)) && instr_done;
	endproperty
	a_flag: assert property (p_flag) else $error("flag update wrong");

	property p_qadvance;
		@(posedge mclk) disable iff (!resetn)
		s_qwr_ack ##0 (r.qcnt != `QUEUE_LAST) |=> r.qptr == $past(r.qptr) + 16'h0001;
	endproperty
	a_qadvance: assert property (p_qadvance) else $error("queue pointer not advanced");

	property p_qwrap;
		@(posedge mclk) disable iff (!resetn)
		s_qwr_ack ##0 (r.qcnt == `QUEUE_LAST)
			|=> r.qptr == r.qbase && queue_wrap_irq == r.qien && r.qcnt == 6'h00;
	endproperty
	a_qwrap: assert property (p_qwrap) else $error("queue wrap wrong");

	property p_host_base;
		@(posedge mclk) disable iff (!resetn)
		reg_wr && reg_addr == `REG_GP_QUEUE_PTR |=> r.qptr == $past(reg_wdata);
	endproperty
	a_host_base: assert property (p_host_base) else $error("host base not taken");

	property p_go_waits;
		@(posedge mclk) disable iff (!resetn)
		msg_go |-> $past(r.timer) == 16'h0000;
	endproperty
	a_go_waits: assert property (p_go_waits) else $error("message started early");

	property p_timer_load;
		@(posedge mclk) disable iff (!resetn)
		msg_go && r.ttnm != 16'h0000 |-> r.timer == r.ttnm;
	endproperty
	a_timer_load: assert property (p_timer_load) else $error("timer not loaded");

	property p_ttag_start;
		@(posedge mclk) disable iff (!resetn)
		msg_go |-> ram_req && ram_we && ram_addr == 13'(r.param + `MB_TTAG);
	endproperty
	a_ttag_start: assert property (p_ttag_start) else $error("start tag not written");

endmodule : bc_sequencer_queue_msg_blocks
`default_nettype wire

// file: bcq_consts.svh
// Constants for the sequencer queue and message block engine.
`ifndef BCQ_CONSTS_SVH
`define BCQ_CONSTS_SVH

// Register offsets on the host register port, queue pointer reset base, wrap enable bit and last queue index.
`define REG_IRQ_ENABLE      16'h0010
`define REG_GP_FLAG_WRITE   16'h0037
`define REG_GP_QUEUE_PTR    16'h0038
`define QPTR_RST            16'h00c0
`define QWRAP_IEN_BIT       13
`define QUEUE_LAST          6'h3f

// Op codes seen on the instruction port.
`define OP_DECREMENT_SKIP_IF_ZERO 5'h0b
`define OP_FLAG_MODIFY_INSTR      5'h0c
`define OP_PUSH_IMM         5'h0d
`define OP_PUSH_VAL         5'h0e
`define OP_PUSH_MEM         5'h0f
`define OP_EXEC_MSG         5'h10

// Message control/status block word offsets.
`define MB_CTRL             16'h0000
`define MB_TTNM             4'h3
`define MB_TTAG             16'h0004
`define MB_BSW              16'h0005
`define MB_W7               16'h0006
`define MB_STATUS           16'h0007
`define MB_RX_STATUS        16'h0009

// Message timer: one count per microsecond at a 40 ns clock.
`define TTNM_LSB_NS         1000
`define MCLK_NS             40
`define TTNM_PRE_LAST       5'((`TTNM_LSB_NS / `MCLK_NS) - 1)

`endif

// file: bcq_pkg.sv
// Types for the sequencer queue and message block engine.
package bcq_pkg;

	typedef enum logic [9:0] {
		S_IDLE     = 10'h001,
		S_DEC_RD   = 10'h002,
		S_DEC_WR   = 10'h004,
		S_PMEM     = 10'h008,
		S_QWR      = 10'h010,
		S_MSG_RD   = 10'h020,
		S_MSG_WAIT = 10'h040,
		S_MSG_TT   = 10'h080,
		S_MSG_RUN  = 10'h100,
		S_MSG_WB   = 10'h200
	} state_e;

	typedef struct packed {
		state_e            st;
		logic [15:0]       param;
		logic [3:0]        cnt;
		logic [15:0]       data;
		logic [15:0]       ttnm;
		logic [15:0]       timer;
		logic [4:0]        pre;
		logic [31:0]       ttag;
		logic [7:0]        flags;
		logic [15:0]       qbase;
		logic [15:0]       qptr;
		logic [5:0]        qcnt;
		logic              qien;
		logic [1:0][15:0]  fmem;
		logic              fwp;
		logic              frp;
		logic [1:0]        fcnt;
		logic              done;
		logic              skip;
		logic              ram_req;
		logic              ram_we;
		logic [12:0]       ram_addr;
		logic [15:0]       ram_wdata;
		logic [15:0]       rdata;
		logic              irq;
		logic              go;
		logic [15:0]       ctrl;
		logic [15:0]       cmd;
		logic [15:0]       dptr;
		logic              dptr_used;
	} state_s;

endpackage : bcq_pkg

// file: shared_ram_model.sv
// Shared RAM model that answers the block's memory requests after a variable wait.
`timescale 1ns/10ps
`default_nettype none

module shared_ram_model (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        resetn,
	// Memory port.
	input  wire logic        ram_req,
	input  wire logic        ram_we,
	input  wire logic [12:0] ram_addr,
	input  wire logic [15:0] ram_wdata,
	output logic      [15:0] ram_rdata,
	output logic             ram_ack,
	// High at an acknowledge makes the following answer wait one to six cycles.
	input  wire logic        slow
);
	logic [15:0] mem [0:8191];
	int          wait_n;

	// Outside the acknowledge cycle the read data flips every cycle, so stale data never matches.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ram_ack   <= 1'b0;
			ram_rdata <= 16'h5555;
			wait_n    <= 0;
		end else if (ram_ack) begin
			ram_ack   <= 1'b0;
			ram_rdata <= ~ram_rdata;
			wait_n    <= slow ? $urandom_range(6, 1) : 0;
		end else if (ram_req && wait_n == 0) begin
			ram_ack   <= 1'b1;
			ram_rdata <= mem[ram_addr];
			if (ram_we)
				mem[ram_addr] <= ram_wdata;
		end else begin
			ram_rdata <= ~ram_rdata;
			if (ram_req)
				wait_n <= wait_n - 1;
		end
	end
endmodule : shared_ram_model
`default_nettype wire

// file: tb.sv
// Self-checking bench for the sequencer queue and message block engine.
`timescale 1ns/10ps
`default_nettype none
`include "bcq_consts.svh"

module tb;
	import bcq_pkg::*;

	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        instr_valid = 1'b0;
	logic [4:0]  instr_op = 5'h00;
	logic [15:0] instr_param = 16'h0000;
	logic        cond_true = 1'b0;
	logic [15:0] push_value = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic [31:0] time_count = 32'h5a5a_0000;
	logic        time32_sel = 1'b1;
	logic        msg_end = 1'b0;
	logic        end_rt_rt = 1'b1;
	logic [15:0] end_bsw = 16'h0000;
	logic [15:0] end_status = 16'h0000;
	logic [15:0] end_rx_status = 16'h0000;
	logic [15:0] end_last_tx = 16'h0000;
	logic        slow = 1'b0;
	logic        instr_done, skip_next, ram_req, ram_we, ram_ack, msg_go, msg_dptr_used;
	logic        queue_wrap_irq;
	logic [12:0] ram_addr;
	logic [15:0] ram_wdata, ram_rdata, reg_rdata, msg_ctrl, msg_cmd, msg_dptr;
	logic [7:0]  gp_flags, ef;
	logic [15:0] p, v;
	logic [31:0] t1;
	int          fails = 0, n_compared = 0, cyc = 0, irq_n = 0, end_cnt = 0, i, k, seed;
	logic        exp_q [$];
	logic [15:0] qw [$];
	int          go_cyc [$];
	logic [31:0] go_tag [$];

	bc_sequencer_queue_msg_blocks bc_sequencer_queue_msg_blocks_inst (
		.mclk(mclk), .resetn(resetn), .instr_valid(instr_valid), .instr_op(instr_op),
		.instr_param(instr_param), .cond_true(cond_true), .push_value(push_value),
		.instr_done(instr_done), .skip_next(skip_next), .ram_req(ram_req), .ram_we(ram_we),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ram_ack(ram_ack),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .time_count(time_count), .time32_sel(time32_sel),
		.msg_end(msg_end), .end_rt_rt(end_rt_rt), .end_bsw(end_bsw), .end_status(end_status),
		.end_rx_status(end_rx_status), .end_last_tx(end_last_tx), .msg_go(msg_go),
		.msg_ctrl(msg_ctrl), .msg_cmd(msg_cmd), .msg_dptr(msg_dptr),
		.msg_dptr_used(msg_dptr_used), .gp_flags(gp_flags), .queue_wrap_irq(queue_wrap_irq));

	shared_ram_model shared_ram_model_inst (
		.mclk(mclk), .resetn(resetn), .ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ram_ack(ram_ack), .slow(slow));

	always #20 mclk = ~mclk;

	always @(posedge mclk) time_count <= time_count + 32'h1;

	// Stands in for the protocol engine: a message ends twenty-one cycles after it starts.
	always @(posedge mclk) begin
		msg_end <= (end_cnt == 1);
		if (msg_go === 1'b1)
			end_cnt <= 20;
		else if (end_cnt > 0)
			end_cnt <= end_cnt - 1;
	end

	function automatic logic [15:0] m(input int a);
		return shared_ram_model_inst.mem[a];
	endfunction : m

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	always @(negedge mclk) begin
		if (instr_done === 1'b1) begin
			if (exp_q.size() == 0)
				chk(32'h1, 32'h0);
			else
				chk(skip_next, exp_q.pop_front());
		end
		if (queue_wrap_irq === 1'b1)
			irq_n++;
		if (msg_go === 1'b1) begin
			go_cyc.push_back(cyc);
			go_tag.push_back(time_count);
		end
		cyc++;
	end

	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// The offer is released at the edge that samples done high; the engine takes nothing then.
	task automatic do_instr(input logic [4:0] op, input logic [15:0] pa, input logic c,
			input logic [15:0] pv, input logic s);
		int n;
		exp_q.push_back(s);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_op    <= op;
		instr_param <= pa;
		cond_true   <= c;
		push_value  <= pv;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (instr_done !== 1'b1 && n < 4000);
		instr_valid <= 1'b0;
		if (n >= 4000)
			chk(32'h0, 32'h1);
	endtask : do_instr

	task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_check(input logic [15:0] a, input logic [15:0] e);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk(reg_rdata, e);
	endtask : reg_check

	initial begin
		#(40 * 50000);
		fails++;
		report_and_stop();
	end

	initial begin
		seed = $urandom(7);
		for (i = 0; i < 64; i++)
			shared_ram_model_inst.mem[16'h0400 + i] = 16'hc000 + 16'(i);
		shared_ram_model_inst.mem[16'h0300] = 16'h0001;
		shared_ram_model_inst.mem[16'h0301] = 16'h0003;
		shared_ram_model_inst.mem[16'h0302] = 16'h0005;
		// Host-built blocks: control, command, data pointer, time to next.
		shared_ram_model_inst.mem[16'h0200] = 16'h1234;
		shared_ram_model_inst.mem[16'h0201] = 16'h0c22;
		shared_ram_model_inst.mem[16'h0202] = 16'h0500;
		shared_ram_model_inst.mem[16'h0203] = 16'h0004;
		shared_ram_model_inst.mem[16'h0210] = 16'h4321;
		shared_ram_model_inst.mem[16'h0211] = 16'h0c00;
		shared_ram_model_inst.mem[16'h0212] = 16'h0600;
		shared_ram_model_inst.mem[16'h0213] = 16'h0000;
		shared_ram_model_inst.mem[16'h0219] = 16'hdead;
		end_bsw       = 16'($urandom);
		end_status    = 16'($urandom);
		end_rx_status = 16'($urandom);
		end_last_tx   = 16'($urandom);
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		reg_check(`REG_GP_QUEUE_PTR, `QPTR_RST);
		reg_check(`REG_GP_FLAG_WRITE, 16'h0000);
		reg_write(`REG_GP_FLAG_WRITE, 16'h00a5);
		@(negedge mclk);
		ef = 8'ha5;
		chk(gp_flags, ef);
		for (i = 0; i < 12; i++) begin
			p = 16'($urandom);
			for (k = 0; k < 8; k++) begin
				case ({p[8 + k], p[k]})
					2'b01: ef[k] = 1'b1;
					2'b10: ef[k] = 1'b0;
					2'b11: ef[k] = ~ef[k];
					default: ef[k] = ef[k];
				endcase
			end
			do_instr(`OP_FLAG_MODIFY_INSTR, p, i[0], 16'h0000, 1'b0);
			chk(gp_flags, ef);
		end
		slow <= 1'b1;
		do_instr(`OP_DECREMENT_SKIP_IF_ZERO, 16'h0300, 1'b1, 16'h0000, 1'b1);
		do_instr(`OP_DECREMENT_SKIP_IF_ZERO, 16'h0301, 1'b1, 16'h0000, 1'b0);
		do_instr(`OP_DECREMENT_SKIP_IF_ZERO, 16'h0302, 1'b0, 16'h0000, 1'b0);
		chk(m(16'h0300), 16'h0000);
		chk(m(16'h0301), 16'h0002);
		chk(m(16'h0302), 16'h0005);
		reg_write(`REG_IRQ_ENABLE, 16'h2000);
		reg_check(`REG_IRQ_ENABLE, 16'h2000);
		reg_write(`REG_GP_QUEUE_PTR, 16'h0100);
		reg_check(`REG_GP_QUEUE_PTR, 16'h0100);
		do_instr(`OP_PUSH_IMM, 16'hbeef, 1'b0, 16'h0000, 1'b0);
		do_instr(`OP_PUSH_MEM, 16'h0400, 1'b0, 16'h0000, 1'b0);
		do_instr(5'h1f, 16'h0000, 1'b1, 16'h0000, 1'b0);
		for (i = 0; i < 64; i++) begin
			p = 16'($urandom);
			v = 16'($urandom);
			if (i % 3 == 0)
				qw.push_back(p);
			else if (i % 3 == 1)
				qw.push_back(v);
			else
				qw.push_back(16'hc000 + 16'(i));
			if (i % 3 == 2)
				do_instr(`OP_PUSH_MEM, 16'h0400 + 16'(i), 1'b1, v, 1'b0);
			else
				do_instr(i % 3 ? `OP_PUSH_VAL : `OP_PUSH_IMM, p, 1'b1, v, 1'b0);
			if (i == 9) begin
				repeat (30) @(posedge mclk);
				reg_check(`REG_GP_QUEUE_PTR, 16'h010a);
			end
		end
		repeat (60) @(posedge mclk);
		for (i = 0; i < 64; i++)
			chk(m(16'h0100 + i), qw[i]);
		reg_check(`REG_GP_QUEUE_PTR, 16'h0100);
		chk(irq_n, 1);
		do_instr(`OP_EXEC_MSG, 16'h0200, 1'b1, 16'h0000, 1'b0);
		t1 = time_count;
		chk(msg_ctrl, 16'h1234);
		chk(msg_cmd, 16'h0c22);
		chk(msg_dptr, 16'h0500);
		chk(msg_dptr_used, 1'b1);
		chk(m(16'h0204) >= go_tag[0][15:0] + 16'd20 && m(16'h0204) <= t1[15:0], 1'b1);
		chk(m(16'h0205), end_bsw);
		chk(m(16'h0206), 16'h5a5a);
		chk(m(16'h0207), end_status);
		chk(m(16'h0209), end_rx_status);
		chk(m(16'h0200), 16'h1234);
		time32_sel <= 1'b0;
		end_rt_rt  <= 1'b0;
		do_instr(`OP_EXEC_MSG, 16'h0210, 1'b1, 16'h0000, 1'b0);
		chk(msg_dptr_used, 1'b0);
		chk(m(16'h0216), end_last_tx);
		chk(m(16'h0219), 16'hdead);
		chk(go_cyc[1] - go_cyc[0] >= 100, 1'b1);
		chk(go_cyc[1] - go_cyc[0] <= 110, 1'b1);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
